// ===== tld_params.svh
// Opcodes, widths and reset values for the timer load instruction decoder.
// Assumes inclusion by bare name from the package and the design file.
`ifndef TLD_PARAMS_SVH
`define TLD_PARAMS_SVH
`define TLD_OP_W 10
`define TLD_OP_LOAD_T2 10'h231
`define TLD_OP_LOAD_T3 10'h232
`define TLD_OP_LOAD_T4 10'h233
`define TLD_OP_LOAD_RL4H 10'h237
`define TLD_NIB_W 4
`define TLD_BYTE_W 8
`define TLD_RST_BYTE 8'h00
`endif

// ===== tld_pkg.sv
// Types shared by the timer load instruction decoder.
// Assumes tld_params.svh is on the include path.
`include "tld_params.svh"
package tld_pkg;
  typedef enum logic [2:0] {
    op_none,
    load_second_timer_op,
    load_third_timer_op,
    load_fourth_timer_op,
    load_fourth_reload_high_op
  } tld_op_t;
endpackage : tld_pkg

// ===== timer_reload_load_instructions.sv
// Decoder and executor of four single-cycle timer load instructions.
// Assumes the CPU core presents one opcode with a valid strobe per instruction cycle.
// Contract
// - Opcode 1000110001 loads timer 2; one word, one cycle.
// - Timer 2 load: B to upper nibble, A to lower, timer and reload.
// - Opcode 1000110010 loads timer 3; one word, one cycle.
// - Timer 3 load: B to upper nibble, A to lower, timer and reload.
// - Opcode 1000110011 loads timer 4; one word, one cycle.
// - Timer 4 load: B upper, A lower into timer 4 and low reload.
// - Opcode 1000110111 writes B and A into timer 4 high reload only.
`include "tld_params.svh"
module timer_reload_load_instructions
  import tld_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [`TLD_OP_W-1:0] instr_i,
  input wire logic [`TLD_NIB_W-1:0] acc_i,
  input wire logic [`TLD_NIB_W-1:0] reg_b_i,
  output logic [`TLD_BYTE_W-1:0] timer2_load_o,
  output logic timer2_load_en_o,
  output logic [`TLD_BYTE_W-1:0] timer3_load_o,
  output logic timer3_load_en_o,
  output logic [`TLD_BYTE_W-1:0] timer4_load_o,
  output logic timer4_load_en_o,
  output logic [`TLD_BYTE_W-1:0] second_timer_reload_o,
  output logic [`TLD_BYTE_W-1:0] third_timer_reload_o,
  output logic [`TLD_BYTE_W-1:0] fourth_timer_reload_low_o,
  output logic [`TLD_BYTE_W-1:0] fourth_timer_reload_high_o,
  output logic hit_o,
  output logic carry_write_o,
  output logic skip_next_o
);

  typedef struct packed {
    logic [`TLD_BYTE_W-1:0] t2;
    logic t2_en;
    logic [`TLD_BYTE_W-1:0] t3;
    logic t3_en;
    logic [`TLD_BYTE_W-1:0] t4;
    logic t4_en;
    logic [`TLD_BYTE_W-1:0] rl2;
    logic [`TLD_BYTE_W-1:0] rl3;
    logic [`TLD_BYTE_W-1:0] rl4_lo;
    logic [`TLD_BYTE_W-1:0] rl4_hi;
    logic hit;
    logic carry;
    logic skip;
  } tld_state_t;

  tld_state_t st_r;
  tld_state_t st_nxt;
  tld_op_t op;
  logic [`TLD_BYTE_W-1:0] ba;

  function automatic tld_op_t decode(input logic [`TLD_OP_W-1:0] code);
    tld_op_t res;
    res = op_none;
    if (code == `TLD_OP_LOAD_T2) begin
      res = load_second_timer_op;
    end else if (code == `TLD_OP_LOAD_T3) begin
      res = load_third_timer_op;
    end else if (code == `TLD_OP_LOAD_T4) begin
      res = load_fourth_timer_op;
    end else if (code == `TLD_OP_LOAD_RL4H) begin
      res = load_fourth_reload_high_op;
    end
    return res;
  endfunction : decode

  always_comb begin
    op = instr_valid_i ? decode(instr_i) : op_none;
    ba = {reg_b_i, acc_i};
    st_nxt = st_r;
    st_nxt.t2_en = 1'b0;
    st_nxt.t3_en = 1'b0;
    st_nxt.t4_en = 1'b0;
    st_nxt.hit = (op != op_none);
    st_nxt.carry = 1'b0;
    st_nxt.skip = 1'b0;
    unique case (op)
      op_none: begin
      end
      load_second_timer_op: begin
        st_nxt.t2 = ba;
        st_nxt.rl2 = ba;
        st_nxt.t2_en = 1'b1;
      end
      load_third_timer_op: begin
        st_nxt.t3 = ba;
        st_nxt.rl3 = ba;
        st_nxt.t3_en = 1'b1;
      end
      load_fourth_timer_op: begin
        st_nxt.t4 = ba;
        st_nxt.rl4_lo = ba;
        st_nxt.t4_en = 1'b1;
      end
      load_fourth_reload_high_op: begin
        st_nxt.rl4_hi = ba;
      end
    endcase
  end

  // Every write lands at the single edge closing the execution cycle.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.t2 <= `TLD_RST_BYTE;
      st_r.t3 <= `TLD_RST_BYTE;
      st_r.t4 <= `TLD_RST_BYTE;
      st_r.rl2 <= `TLD_RST_BYTE;
      st_r.rl3 <= `TLD_RST_BYTE;
      st_r.rl4_lo <= `TLD_RST_BYTE;
      st_r.rl4_hi <= `TLD_RST_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign timer2_load_o = st_r.t2;
  assign timer2_load_en_o = st_r.t2_en;
  assign timer3_load_o = st_r.t3;
  assign timer3_load_en_o = st_r.t3_en;
  assign timer4_load_o = st_r.t4;
  assign timer4_load_en_o = st_r.t4_en;
  assign second_timer_reload_o = st_r.rl2;
  assign third_timer_reload_o = st_r.rl3;
  assign fourth_timer_reload_low_o = st_r.rl4_lo;
  assign fourth_timer_reload_high_o = st_r.rl4_hi;
  assign hit_o = st_r.hit;
  assign carry_write_o = st_r.carry;
  assign skip_next_o = st_r.skip;

  property p_t2_opcode;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      instr_valid_i && instr_i == 10'h231 |=> timer2_load_en_o && hit_o;
  endproperty
  a_t2_opcode: assert property (p_t2_opcode) else $error("timer 2 opcode not taken");

  property p_t2_data;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      instr_valid_i && instr_i == 10'h231 |=>
        timer2_load_o == {$past(reg_b_i), $past(acc_i)} && second_timer_reload_o == timer2_load_o;
  endproperty
  a_t2_data: assert property (p_t2_data) else $error("timer 2 data wrong");

  property p_t3_opcode;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      timer3_load_en_o |-> $past(instr_valid_i) && $past(instr_i) == 10'h232;
  endproperty
  a_t3_opcode: assert property (p_t3_opcode) else $error("timer 3 load without opcode");

  property p_t3_data;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      instr_valid_i && instr_i == 10'h232 |=>
        third_timer_reload_o == {$past(reg_b_i), $past(acc_i)} && timer3_load_o == third_timer_reload_o;
  endproperty
  a_t3_data: assert property (p_t3_data) else $error("timer 3 data wrong");

  property p_t4_opcode;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      instr_valid_i && instr_i == 10'h233 |=> timer4_load_en_o
        ##1 (timer4_load_en_o == ($past(instr_valid_i) && $past(instr_i) == 10'h233));
  endproperty
  a_t4_opcode: assert property (p_t4_opcode) else $error("timer 4 strobe wrong");

  property p_t4_data;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      instr_valid_i && instr_i == 10'h233 |=>
        fourth_timer_reload_low_o == {$past(reg_b_i), $past(acc_i)} && $stable(fourth_timer_reload_high_o);
  endproperty
  a_t4_data: assert property (p_t4_data) else $error("timer 4 low reload wrong");

  property p_r4h;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      instr_valid_i && instr_i == 10'h237 |=>
        fourth_timer_reload_high_o == {$past(reg_b_i), $past(acc_i)} && !timer4_load_en_o
        && $stable(fourth_timer_reload_low_o);
  endproperty
  a_r4h: assert property (p_r4h) else $error("high reload write wrong");

  property p_no_side;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      hit_o |-> !carry_write_o && !skip_next_o;
  endproperty
  a_no_side: assert property (p_no_side) else $error("carry or skip touched");

  property p_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !instr_valid_i |=> !hit_o && $stable(second_timer_reload_o) && $stable(fourth_timer_reload_high_o);
  endproperty
  a_hold: assert property (p_hold) else $error("state changed without instruction");

  // Any other opcode must leave every byte untouched and every strobe low.
  property p_refused;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      instr_valid_i && !(instr_i inside {10'h231, 10'h232, 10'h233, 10'h237}) |=> !hit_o
        && !timer2_load_en_o && !timer3_load_en_o && !timer4_load_en_o
        && $stable({timer2_load_o, timer3_load_o, timer4_load_o, second_timer_reload_o})
        && $stable({third_timer_reload_o, fourth_timer_reload_low_o, fourth_timer_reload_high_o});
  endproperty
  a_refused: assert property (p_refused) else $error("unknown opcode changed state");

  property p_hit_src;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      hit_o |-> $past(instr_valid_i) && ($past(instr_i) inside {10'h231, 10'h232, 10'h233, 10'h237});
  endproperty
  a_hit_src: assert property (p_hit_src) else $error("hit without a load opcode");

  property p_en_onehot;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $onehot0({timer2_load_en_o, timer3_load_en_o, timer4_load_en_o})
        && (hit_o || !(timer2_load_en_o || timer3_load_en_o || timer4_load_en_o));
  endproperty
  a_en_onehot: assert property (p_en_onehot) else $error("load strobes not one hot");

  c_t2: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) timer2_load_en_o);
  c_t4_then_r4h: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    timer4_load_en_o ##1 (hit_o && !timer4_load_en_o));
  c_t3_back: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    timer3_load_en_o ##1 timer3_load_en_o);
  c_r4h_only: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    hit_o && !timer2_load_en_o && !timer3_load_en_o && !timer4_load_en_o);

endmodule : timer_reload_load_instructions

// ===== cpu_core_model.sv
// CPU core model that presents one instruction word per cycle to the timer load decoder.
// Assumes its caller acts just after a falling edge of the instruction clock.
module cpu_core_model (
  output logic instr_valid_o,
  output logic [9:0] instr_o,
  output logic [3:0] acc_o,
  output logic [3:0] reg_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    instr_valid_o = 1'b0;
    instr_o = 10'h000;
    acc_o = 4'h0;
    reg_b_o = 4'h0;
  end
  task automatic drive(input logic v, input logic [9:0] op, input logic [3:0] a, b);
    instr_valid_o = v;
    instr_o = op;
    acc_o = a;
    reg_b_o = b;
  endtask : drive
  // Released lines do not keep their last value, so idle flips them.
  task automatic idle();
    drive(1'b0, ~instr_o, ~acc_o, ~reg_b_o);
  endtask : idle
endmodule : cpu_core_model

// ===== tb.sv
// Self-checking testbench of the timer load instruction decoder.
// Assumes tld_params.svh on the include path and the CPU core model beside it.
`include "tld_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i;
  logic [9:0] instr_i;
  logic [3:0] acc_i, reg_b_i, xen;
  logic [7:0] timer2_load_o, timer3_load_o, timer4_load_o, second_timer_reload_o;
  logic [7:0] third_timer_reload_o, fourth_timer_reload_low_o, fourth_timer_reload_high_o;
  logic timer2_load_en_o, timer3_load_en_o, timer4_load_en_o, hit_o, carry_write_o, skip_next_o;
  logic [7:0] x2, x3, x4, xr2, xr3, xr4l, xr4h;
  int mismatches = 0;
  int n_tests = 0;
  logic [9:0] ops [4] = '{`TLD_OP_LOAD_T2, `TLD_OP_LOAD_T3, `TLD_OP_LOAD_T4, `TLD_OP_LOAD_RL4H};
  logic [9:0] bad_ops [5] = '{10'h230, 10'h234, 10'h235, 10'h236, 10'h331};
  always #25 clk_sys_i = ~clk_sys_i;
  cpu_core_model cpu (.instr_valid_o(instr_valid_i), .instr_o(instr_i), .acc_o(acc_i),
    .reg_b_o(reg_b_i));
  timer_reload_load_instructions uut (.clk_sys_i, .rst_n_i, .instr_valid_i, .instr_i, .acc_i,
    .reg_b_i, .timer2_load_o, .timer2_load_en_o, .timer3_load_o, .timer3_load_en_o,
    .timer4_load_o, .timer4_load_en_o, .second_timer_reload_o, .third_timer_reload_o,
    .fourth_timer_reload_low_o, .fourth_timer_reload_high_o, .hit_o, .carry_write_o,
    .skip_next_o);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic check_all();
    chk({timer2_load_o, second_timer_reload_o, timer3_load_o, third_timer_reload_o, timer4_load_o,
      fourth_timer_reload_low_o, fourth_timer_reload_high_o}, {x2, xr2, x3, xr3, x4, xr4l, xr4h});
    chk({hit_o, timer4_load_en_o, timer3_load_en_o, timer2_load_en_o, carry_write_o, skip_next_o},
      {xen, 2'b00});
  endtask : check_all
  // Drives one instruction cycle and judges the outputs one cycle later.
  task automatic issue(input logic v, input logic [9:0] op, input logic [3:0] a, b);
    xen = 4'h0;
    if (v) case (op)
      `TLD_OP_LOAD_T2: {x2, xr2, xen} = {b, a, b, a, 4'h9};
      `TLD_OP_LOAD_T3: {x3, xr3, xen} = {b, a, b, a, 4'ha};
      `TLD_OP_LOAD_T4: {x4, xr4l, xen} = {b, a, b, a, 4'hc};
      `TLD_OP_LOAD_RL4H: {xr4h, xen} = {b, a, 4'h8};
      default: ;
    endcase
    cpu.drive(v, op, a, b);
    @(negedge clk_sys_i);
    check_all();
  endtask : issue
  task automatic do_reset();
    rst_n_i = 1'b0;
    cpu.idle();
    repeat (5) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    {x2, x3, x4, xr2, xr3, xr4l, xr4h, xen} = '0;
    @(negedge clk_sys_i);
    check_all();
  endtask : do_reset
  task automatic s_back_to_back();
    for (int i = 0; i < 4; i++) issue(1'b1, ops[i], 4'(i + 1), 4'(9 - i));
    for (int i = 3; i >= 0; i--) issue(1'b1, ops[i], 4'(15 - i), 4'(i + 4));
    issue(1'b1, `TLD_OP_LOAD_T2, 4'h0, 4'hf);
    repeat (3) issue(1'b0, ~instr_i, ~acc_i, ~reg_b_i);
  endtask : s_back_to_back
  task automatic s_refused();
    for (int i = 0; i < 4; i++) issue(1'b0, ops[i], 4'h6, 4'h6);
    for (int i = 0; i < 5; i++) issue(1'b1, bad_ops[i], 4'h3, 4'hc);
  endtask : s_refused
  task automatic s_mid_reset();
    issue(1'b1, `TLD_OP_LOAD_T4, 4'h7, 4'h1);
    issue(1'b1, `TLD_OP_LOAD_RL4H, 4'h2, 4'hd);
    do_reset();
    issue(1'b1, `TLD_OP_LOAD_T3, 4'he, 4'h8);
    issue(1'b1, `TLD_OP_LOAD_T3, 4'h1, 4'h4);
    issue(1'b0, 10'h000, 4'h0, 4'h0);
  endtask : s_mid_reset
  task automatic final_report();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  initial begin
    do_reset();
    s_back_to_back();
    s_refused();
    s_mid_reset();
    final_report();
  end
  initial begin
    repeat (500) @(posedge clk_sys_i);
    mismatches++;
    final_report();
  end
endmodule : tb
